// *** include/ctl_port_defs.vh ***
// constants for the control port and lock alarm block
// assumes 8-bit registers addressed by an 8-bit pointer
`ifndef CTL_PORT_DEFS_VH
`define CTL_PORT_DEFS_VH

// configuration registers that need an internal calibration after a change
`define ADDR_BYPASS_KEEPALIVE 8'h00
`define ADDR_BANDWIDTH 8'h02
`define ADDR_HISTORY_DELAY 8'h04
`define ADDR_INPUT_FORMAT 8'h05
`define ADDR_HISTORY_AVERAGE 8'h09
`define ADDR_OUTPUT_DISABLES 8'h0A
`define ADDR_INPUT_POWER_DOWN 8'h0B
`define ADDR_VALIDATION_TIME 8'h13
`define ADDR_HS_DIVIDER 8'h19
`define ADDR_OUT1_LOW_DIVIDER 8'h1F
`define ADDR_OUT2_LOW_DIVIDER 8'h22
`define ADDR_FEEDBACK_DIVIDER 8'h28
`define ADDR_INPUT1_PRESCALER 8'h2B
`define ADDR_INPUT2_PRESCALER 8'h2E
`define CFG_RESET 8'h00

// block's own control, status and calibration registers
`define ADDR_ALARM_CTRL 8'h30
`define ADDR_STATUS 8'h31
`define ADDR_CALIBRATION 8'h32
`define ALARM_CTRL_RESET 2'h0
`define BIT_ALARM_ENABLE 0
`define BIT_ALARM_POLARITY 1
`define BIT_STATUS_UNLOCKED 0
`define BIT_STATUS_CAL_PENDING 1
`define BIT_CAL_START 0

// i2c target address upper bits
`define I2C_ADDR_UPPER 4'hD

// spi instruction codes
`define SPI_CMD_SET_ADDR 8'h00
`define SPI_CMD_WRITE 8'h40
`define SPI_CMD_READ 8'h80
`define SPI_CMD_READ_INC 8'hA0

// strap capture waits for the synchroniser to fill after reset release
`define STRAP_WAIT 2'h3

`endif

// *** core/sync2.v ***
// two flip-flop synchroniser for a group of independent levels
// assumes each bit is a slow level or a clock far below ref_clk_i
`timescale 1ns/10ps
module sync2 #(
  parameter WIDTH = 9
) (
  input wire ref_clk_i,
  input wire rst_n_i,
  input wire [WIDTH-1:0] async_i,
  output wire [WIDTH-1:0] sync_o
);
  reg [WIDTH-1:0] meta_q;
  reg [WIDTH-1:0] sync_q;

  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_q <= {WIDTH{1'b0}};
      sync_q <= {WIDTH{1'b0}};
    end else begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;
endmodule

// *** core/ctl_port.v ***
// control port (i2c or spi target), register file and lock alarm pin
// assumes all pins are asynchronous and scl runs far below ref_clk_i
// Function
// (R1) with the alarm enabled the alarm pin is driven high while unlocked and low while locked
// (R2) with the alarm disabled the alarm pin is not driven
// (R3) a polarity bit inverts the active level of the alarm pin
// (R4) a read-only status bit always shows the lock state
// (R5) the input select pin chooses the first clock at 0 and the second at 1
// (R6) the board drives the input select pin to a definite level
// (R7) the serial clock pin is the port clock in both modes and comes from the host
// (R8) the shared data pin is open-drain i2c data with strap 0 and spi output with strap 1
// (R9) in i2c mode the target address is 1101 followed by the three address straps
// (R10) in spi mode the two lower address straps are ignored
// (R11) the upper address pin is address bit two in i2c and the select input in spi
// (R12) the serial input pin is ignored in i2c and is spi data in spi mode
// (R13) the protocol strap chooses i2c at 0 and spi at 1
// (R14) the host issues an internal calibration after changing the listed registers
// (R15) in spi mode the output is released while the select input is inactive
`timescale 1ns/10ps
`include "ctl_port_defs.vh"
module ctl_port (
  input wire ref_clk_i,
  input wire rst_n_i,
  input wire serial_clock_i,
  input wire shared_data_pin_i,
  output wire shared_data_pin_o,
  output wire shared_data_pin_oe_o,
  input wire address_strap_zero_i,
  input wire address_strap_one_i,
  input wire address_two_or_select_i,
  input wire spi_serial_input_i,
  input wire port_protocol_strap_i,
  input wire manual_input_select_i,
  input wire pll_locked_i,
  output wire lock_alarm_pin_o,
  output wire lock_alarm_pin_oe_o,
  output wire use_second_clock_input_o,
  output wire internal_calibration_o,
  output wire calibration_pending_o
);
  localparam [4:0] S_IDLE = 5'h01;
  localparam [4:0] S_RX = 5'h02;
  localparam [4:0] S_RACK = 5'h04;
  localparam [4:0] S_TX = 5'h08;
  localparam [4:0] S_TACK = 5'h10;

  wire [8:0] pins_s;
  sync2 #(.WIDTH(9)) u_sync (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .async_i({pll_locked_i, manual_input_select_i, port_protocol_strap_i,
              spi_serial_input_i, address_two_or_select_i, address_strap_one_i,
              address_strap_zero_i, shared_data_pin_i, serial_clock_i}),
    .sync_o(pins_s)
  );
  wire scl_s = pins_s[0];  // [R7]
  wire sda_s = pins_s[1];
  wire addr0_s = pins_s[2];
  wire addr1_s = pins_s[3];
  wire addr2_sel_s = pins_s[4];
  wire spi_in_s = pins_s[5];
  wire strap_s = pins_s[6];
  wire sel_s = pins_s[7];
  wire locked_s = pins_s[8];

  reg scl_p_q;
  reg sda_p_q;
  reg [1:0] strap_cnt_q;
  reg strap_done_q;
  reg spi_q;
  reg [4:0] state_q;
  reg [3:0] bit_cnt_q;
  reg [1:0] byte_idx_q;
  reg rw_q;
  reg nack_q;
  reg [7:0] sh_q;
  reg [7:0] tx_q;
  reg [7:0] cmd_q;
  reg [7:0] ptr_q;
  reg sda_out_q;
  reg sda_oe_q;
  reg wr_en_q;
  reg [7:0] wr_addr_q;
  reg [7:0] wr_data_q;
  reg [7:0] regs_q [0:46];
  reg [1:0] alarm_ctrl_q;
  reg cal_pending_q;
  reg cal_pulse_q;
  reg alarm_q;
  reg alarm_oe_q;
  reg sel_q;
  reg [7:0] rd_data;
  integer i;

  wire scl_rise = scl_s & ~scl_p_q;
  wire scl_fall = ~scl_s & scl_p_q;
  wire i2c_start = scl_s & scl_p_q & sda_p_q & ~sda_s;
  wire i2c_stop = scl_s & scl_p_q & ~sda_p_q & sda_s;
  wire [6:0] dev_addr = {`I2C_ADDR_UPPER, addr2_sel_s, addr1_s, addr0_s};  // [R9] [R11]
  wire [7:0] spi_byte = {sh_q[6:0], spi_in_s};  // [R12]
  wire spi_is_read = (cmd_q == `SPI_CMD_READ) || (cmd_q == `SPI_CMD_READ_INC);
  wire spi_cmd_read = (spi_byte == `SPI_CMD_READ) || (spi_byte == `SPI_CMD_READ_INC);

  function is_cfg;
    input [7:0] a;
    begin
      if (a == `ADDR_BYPASS_KEEPALIVE) is_cfg = 1'b1;
      else if (a == `ADDR_BANDWIDTH) is_cfg = 1'b1;
      else if (a == `ADDR_HISTORY_DELAY) is_cfg = 1'b1;
      else if (a == `ADDR_INPUT_FORMAT) is_cfg = 1'b1;
      else if (a == `ADDR_HISTORY_AVERAGE) is_cfg = 1'b1;
      else if (a == `ADDR_OUTPUT_DISABLES) is_cfg = 1'b1;
      else if (a == `ADDR_INPUT_POWER_DOWN) is_cfg = 1'b1;
      else if (a == `ADDR_VALIDATION_TIME) is_cfg = 1'b1;
      else if (a == `ADDR_HS_DIVIDER) is_cfg = 1'b1;
      else if (a == `ADDR_OUT1_LOW_DIVIDER) is_cfg = 1'b1;
      else if (a == `ADDR_OUT2_LOW_DIVIDER) is_cfg = 1'b1;
      else if (a == `ADDR_FEEDBACK_DIVIDER) is_cfg = 1'b1;
      else if (a == `ADDR_INPUT1_PRESCALER) is_cfg = 1'b1;
      else if (a == `ADDR_INPUT2_PRESCALER) is_cfg = 1'b1;
      else is_cfg = 1'b0;
    end
  endfunction

  // read mux; unmapped pointers read as zero
  always @* begin
    rd_data = 8'h00;
    if (is_cfg(ptr_q)) begin
      rd_data = regs_q[ptr_q[5:0]];
    end else if (ptr_q == `ADDR_ALARM_CTRL) begin
      rd_data = {6'h00, alarm_ctrl_q};
    end else if (ptr_q == `ADDR_STATUS) begin
      rd_data = {6'h00, cal_pending_q, ~locked_s};  // [R4]
    end
  end

  // protocol strap is caught once, after the synchroniser has filled
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      strap_cnt_q <= 2'h0;
      strap_done_q <= 1'b0;
      spi_q <= 1'b0;
    end else if (!strap_done_q) begin
      if (strap_cnt_q == `STRAP_WAIT) begin
        strap_done_q <= 1'b1;
        spi_q <= strap_s;  // [R13]
      end else begin
        strap_cnt_q <= strap_cnt_q + 2'h1;
      end
    end
  end

  // serial engine: one shift path shared by both protocols
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      scl_p_q <= 1'b0;
      sda_p_q <= 1'b1;
      state_q <= S_IDLE;
      bit_cnt_q <= 4'h0;
      byte_idx_q <= 2'h0;
      rw_q <= 1'b0;
      nack_q <= 1'b0;
      sh_q <= 8'h00;
      tx_q <= 8'h00;
      cmd_q <= 8'h00;
      ptr_q <= 8'h00;
      sda_out_q <= 1'b0;
      sda_oe_q <= 1'b0;
      wr_en_q <= 1'b0;
      wr_addr_q <= 8'h00;
      wr_data_q <= 8'h00;
    end else begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
      wr_en_q <= 1'b0;
      if (!strap_done_q) begin
        sda_oe_q <= 1'b0;
      end else if (spi_q) begin
        // spi mode 0: sample on rise, shift out on fall; lower straps unused [R8] [R10]
        if (addr2_sel_s) begin
          sda_oe_q <= 1'b0;  // [R15] [R11]
          bit_cnt_q <= 4'h0;
          byte_idx_q <= 2'h0;
        end else begin
          sda_oe_q <= 1'b1;
          if (scl_rise) begin
            sh_q <= spi_byte;
            if (bit_cnt_q == 4'h7) begin
              bit_cnt_q <= 4'h0;
              byte_idx_q <= {1'b0, ~byte_idx_q[0]};
              if (byte_idx_q == 2'h0) begin
                cmd_q <= spi_byte;
                if (spi_cmd_read) begin
                  tx_q <= rd_data;
                end
                if (spi_byte == `SPI_CMD_READ_INC) begin
                  ptr_q <= ptr_q + 8'h01;
                end
              end else if (cmd_q == `SPI_CMD_SET_ADDR) begin
                ptr_q <= spi_byte;
              end else if (cmd_q == `SPI_CMD_WRITE) begin
                wr_en_q <= 1'b1;
                wr_addr_q <= ptr_q;
                wr_data_q <= spi_byte;
              end
            end else begin
              bit_cnt_q <= bit_cnt_q + 4'h1;
            end
          end else if (scl_fall) begin
            sda_out_q <= spi_is_read & tx_q[7];
            tx_q <= {tx_q[6:0], 1'b0};
          end
        end
      end else begin
        // i2c: open drain, the pin is only ever pulled low [R8]
        sda_out_q <= 1'b0;
        if (i2c_start) begin
          state_q <= S_RX;
          bit_cnt_q <= 4'h0;
          byte_idx_q <= 2'h0;
          sda_oe_q <= 1'b0;
        end else if (i2c_stop) begin
          state_q <= S_IDLE;
          sda_oe_q <= 1'b0;
        end else begin
          case (state_q)
            S_RX: begin
              if (scl_rise && bit_cnt_q != 4'h8) begin
                sh_q <= {sh_q[6:0], sda_s};
                bit_cnt_q <= bit_cnt_q + 4'h1;
              end else if (scl_fall && bit_cnt_q == 4'h8) begin
                if (byte_idx_q == 2'h0) begin
                  if (sh_q[7:1] == dev_addr) begin  // [R9]
                    rw_q <= sh_q[0];
                    sda_oe_q <= 1'b1;
                    state_q <= S_RACK;
                  end else begin
                    state_q <= S_IDLE;
                  end
                end else begin
                  sda_oe_q <= 1'b1;
                  state_q <= S_RACK;
                  if (byte_idx_q == 2'h1) begin
                    ptr_q <= sh_q;
                  end else begin
                    wr_en_q <= 1'b1;
                    wr_addr_q <= ptr_q;
                    wr_data_q <= sh_q;
                    ptr_q <= ptr_q + 8'h01;
                  end
                end
              end
            end
            S_RACK: begin
              if (scl_fall) begin
                bit_cnt_q <= 4'h0;
                if (rw_q) begin
                  tx_q <= rd_data;
                  sda_oe_q <= ~rd_data[7];
                  ptr_q <= ptr_q + 8'h01;
                  state_q <= S_TX;
                end else begin
                  sda_oe_q <= 1'b0;
                  state_q <= S_RX;
                  if (byte_idx_q != 2'h2) begin
                    byte_idx_q <= byte_idx_q + 2'h1;
                  end
                end
              end
            end
            S_TX: begin
              if (scl_fall) begin
                if (bit_cnt_q == 4'h7) begin
                  sda_oe_q <= 1'b0;
                  state_q <= S_TACK;
                end else begin
                  sda_oe_q <= ~tx_q[6];
                  tx_q <= {tx_q[6:0], 1'b0};
                  bit_cnt_q <= bit_cnt_q + 4'h1;
                end
              end
            end
            S_TACK: begin
              if (scl_rise) begin
                nack_q <= sda_s;
              end else if (scl_fall) begin
                if (nack_q) begin
                  state_q <= S_IDLE;
                end else begin
                  tx_q <= rd_data;
                  sda_oe_q <= ~rd_data[7];
                  ptr_q <= ptr_q + 8'h01;
                  bit_cnt_q <= 4'h0;
                  state_q <= S_TX;
                end
              end
            end
            default: begin
              sda_oe_q <= 1'b0;
            end
          endcase
        end
      end
    end
  end

  // register file, calibration request and pin outputs
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (i = 0; i < 47; i = i + 1) begin
        regs_q[i] <= `CFG_RESET;
      end
      alarm_ctrl_q <= `ALARM_CTRL_RESET;
      cal_pending_q <= 1'b0;
      cal_pulse_q <= 1'b0;
      alarm_q <= 1'b0;
      alarm_oe_q <= 1'b0;
      sel_q <= 1'b0;
    end else begin
      cal_pulse_q <= 1'b0;
      if (wr_en_q && is_cfg(wr_addr_q)) begin
        regs_q[wr_addr_q[5:0]] <= wr_data_q;
      end
      if (wr_en_q && wr_addr_q == `ADDR_ALARM_CTRL) begin
        alarm_ctrl_q <= wr_data_q[1:0];
      end
      // a change that lands with the calibration write stays pending
      if (wr_en_q && is_cfg(wr_addr_q)) begin
        cal_pending_q <= 1'b1;  // [R14]
      end else if (wr_en_q && wr_addr_q == `ADDR_CALIBRATION &&
                   wr_data_q[`BIT_CAL_START]) begin
        cal_pending_q <= 1'b0;
      end
      if (wr_en_q && wr_addr_q == `ADDR_CALIBRATION && wr_data_q[`BIT_CAL_START]) begin
        cal_pulse_q <= 1'b1;  // [R14]
      end
      alarm_q <= ~locked_s ^ alarm_ctrl_q[`BIT_ALARM_POLARITY];  // [R1] [R3]
      alarm_oe_q <= alarm_ctrl_q[`BIT_ALARM_ENABLE];  // [R1] [R2]
      sel_q <= sel_s;  // [R5]
    end
  end

  assign shared_data_pin_o = sda_out_q;
  assign shared_data_pin_oe_o = sda_oe_q;
  assign lock_alarm_pin_o = alarm_q;
  assign lock_alarm_pin_oe_o = alarm_oe_q;
  assign use_second_clock_input_o = sel_q;
  assign internal_calibration_o = cal_pulse_q;
  assign calibration_pending_o = cal_pending_q;
endmodule

// *** sim/ctl_port_checker.sv ***
// assertions on the pins of the control port and lock alarm block
// assumes a bind to ctl_port and straps that only change while in reset
`timescale 1ns/10ps
module ctl_port_checker (
  input wire ref_clk_i,
  input wire rst_n_i,
  input wire address_two_or_select_i,
  input wire port_protocol_strap_i,
  input wire manual_input_select_i,
  input wire pll_locked_i,
  input wire shared_data_pin_o,
  input wire shared_data_pin_oe_o,
  input wire lock_alarm_pin_o,
  input wire lock_alarm_pin_oe_o,
  input wire use_second_clock_input_o,
  input wire internal_calibration_o,
  input wire calibration_pending_o
);
  // past values from before a reset must not be trusted, so wait a few edges
  reg [3:0] up_q;
  wire [3:0] up_d;
  wire ready;
  assign up_d = (up_q == 4'hF) ? up_q : up_q + 4'h1;
  assign ready = (up_q >= 4'h8);
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      up_q <= 4'h0;
    end else begin
      up_q <= up_d;
    end
  end
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  a_alarm_follows_lock: assert property (
    ready && $changed(pll_locked_i) |-> ##[1:5] $changed(lock_alarm_pin_o))
    else $error("alarm pin did not follow the lock state");
  a_alarm_enable_steady: assert property (
    ready && $changed(pll_locked_i) |=> $stable(lock_alarm_pin_oe_o)[*4])
    else $error("alarm enable moved with the lock state");
  a_select_latency: assert property (
    ready |-> use_second_clock_input_o == $past(manual_input_select_i, 3))
    else $error("input select not passed on after three edges");
  a_cal_single_pulse: assert property (
    internal_calibration_o |=> !internal_calibration_o)
    else $error("calibration pulse longer than one cycle");
  a_cal_clears_pending: assert property (
    internal_calibration_o |-> ##[0:2] !calibration_pending_o)
    else $error("calibration left pending set");
  a_spi_output_release: assert property (
    (ready && port_protocol_strap_i && address_two_or_select_i)[*5] |-> !shared_data_pin_oe_o)
    else $error("spi output driven while not selected");
  a_spi_output_drive: assert property (
    (ready && port_protocol_strap_i && !address_two_or_select_i)[*5] |-> shared_data_pin_oe_o)
    else $error("spi output not driven while selected");
  a_i2c_open_drain: assert property (
    ready && !port_protocol_strap_i && shared_data_pin_oe_o |-> !shared_data_pin_o)
    else $error("i2c data driven high");
endmodule
bind ctl_port ctl_port_checker chk (
  .ref_clk_i(ref_clk_i),
  .rst_n_i(rst_n_i),
  .address_two_or_select_i(address_two_or_select_i),
  .port_protocol_strap_i(port_protocol_strap_i),
  .manual_input_select_i(manual_input_select_i),
  .pll_locked_i(pll_locked_i),
  .shared_data_pin_o(shared_data_pin_o),
  .shared_data_pin_oe_o(shared_data_pin_oe_o),
  .lock_alarm_pin_o(lock_alarm_pin_o),
  .lock_alarm_pin_oe_o(lock_alarm_pin_oe_o),
  .use_second_clock_input_o(use_second_clock_input_o),
  .internal_calibration_o(internal_calibration_o),
  .calibration_pending_o(calibration_pending_o)
);

// *** sim/host_model.sv ***
// host controller model for the serial port, i2c or spi
// assumes sda_i is the resolved data line level and ref_clk_i paces the bits
`timescale 1ns/10ps
module host_model (
  input wire logic ref_clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic mosi_o,
  output logic ss_n_o,
  output logic sda_low_o
);
  initial begin
    scl_o = 1'b0;
    mosi_o = 1'b0;
    ss_n_o = 1'b1;
    sda_low_o = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask
  // data set while scl is low, read mid high phase to clear the sync lag
  task automatic clk_bit(input logic b, input logic i2c, output logic r);
    mosi_o = i2c ? ~mosi_o : b; // toggles in i2c so that ignoring it is seen
    sda_low_o = i2c & ~b;
    tick(4);
    scl_o = 1'b1;
    tick(2);
    r = sda_i;
    tick(2);
    scl_o = 1'b0;
  endtask
  task automatic spi_frame(input logic [31:0] tx, output logic [31:0] rx);
    logic r;
    ss_n_o = 1'b0; // select frames the transfer
    for (int i = 31; i >= 0; i--) begin
      clk_bit(tx[i], 1'b0, r);
      rx[i] = r;
    end
    tick(4);
    ss_n_o = 1'b1;
    mosi_o = 1'b0;
    tick(4);
  endtask
  // also serves as repeated start since it begins from scl low
  task automatic i2c_start();
    sda_low_o = 1'b0;
    tick(4);
    scl_o = 1'b1;
    tick(4);
    sda_low_o = 1'b1;
    tick(4);
    scl_o = 1'b0;
  endtask
  task automatic i2c_stop();
    sda_low_o = 1'b1;
    tick(4);
    scl_o = 1'b1;
    tick(4);
    sda_low_o = 1'b0;
    tick(4);
  endtask
  // nine bits, a one releases the line so the device may answer
  task automatic i2c_byte(input logic [8:0] tx, output logic [8:0] rx);
    logic r;
    for (int i = 8; i >= 0; i--) begin
      clk_bit(tx[i], 1'b1, r);
      rx[i] = r;
    end
  endtask
endmodule

// *** sim/ctl_port_tb.sv ***
// testbench for ctl_port: spi then i2c register traffic, alarm pin, input select
// assumes host_model as the serial partner and the checker bound to the design
`timescale 1ns/10ps
`include "ctl_port_defs.vh"
module ctl_port_tb;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic strap = 1'b1;
  logic [2:0] straps = 3'h0;
  logic locked = 1'b0;
  logic sel = 1'b0;
  wire scl, mosi, ss_n, sda_low, d_o, d_oe, alarm, alarm_oe, use2, cal, pend;
  // data line has a pull-up; either side may pull it low
  wire sda = ~sda_low & (d_oe ? d_o : 1'b1);
  int n_errors = 0;
  int cmp_count = 0;
  int cal_seen = 0;
  logic [31:0] rs = 32'h9D02;
  logic [7:0] exp_q[$];
  logic [7:0] got_v;
  logic [7:0] d;
  logic [31:0] r32;
  event got_e;
  logic [7:0] mem [14];
  logic [7:0] cal_addr [14] = '{`ADDR_BYPASS_KEEPALIVE, `ADDR_BANDWIDTH, `ADDR_HISTORY_DELAY,
    `ADDR_INPUT_FORMAT, `ADDR_HISTORY_AVERAGE, `ADDR_OUTPUT_DISABLES, `ADDR_INPUT_POWER_DOWN,
    `ADDR_VALIDATION_TIME, `ADDR_HS_DIVIDER, `ADDR_OUT1_LOW_DIVIDER, `ADDR_OUT2_LOW_DIVIDER,
    `ADDR_FEEDBACK_DIVIDER, `ADDR_INPUT1_PRESCALER, `ADDR_INPUT2_PRESCALER};
  ctl_port DUT (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .serial_clock_i(scl),
    .shared_data_pin_i(sda),
    .shared_data_pin_o(d_o),
    .shared_data_pin_oe_o(d_oe),
    .address_strap_zero_i(straps[0]),
    .address_strap_one_i(straps[1]),
    .address_two_or_select_i(strap ? ss_n : straps[2]),
    .spi_serial_input_i(mosi),
    .port_protocol_strap_i(strap),
    .manual_input_select_i(sel),
    .pll_locked_i(locked),
    .lock_alarm_pin_o(alarm),
    .lock_alarm_pin_oe_o(alarm_oe),
    .use_second_clock_input_o(use2),
    .internal_calibration_o(cal),
    .calibration_pending_o(pend)
  );
  host_model host (
    .ref_clk_i(ref_clk_i),
    .sda_i(sda),
    .scl_o(scl),
    .mosi_o(mosi),
    .ss_n_o(ss_n),
    .sda_low_o(sda_low)
  );
  initial begin
    forever #25 ref_clk_i = ~ref_clk_i;
  end
  always @(posedge ref_clk_i) begin
    if (cal === 1'b1) cal_seen++;
  end
  always @(got_e) begin
    cmp_count++;
    if (got_v !== exp_q[0]) begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got_v, exp_q[0]);
    end
    void'(exp_q.pop_front());
  end
  function automatic logic [31:0] nx(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask
  task automatic check(input logic [7:0] g, input logic [7:0] e);
    exp_q.push_back(e);
    got_v = g;
    -> got_e;
    #1;
  endtask
  task automatic end_sim();
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic ib(input logic [7:0] v, input logic ack, output logic [7:0] q);
    logic [8:0] r;
    host.i2c_byte({v, 1'b1}, r);
    check({7'h0, r[0]}, {7'h0, ~ack});
    q = r[8:1];
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    logic [31:0] r;
    logic [7:0] q;
    if (strap) begin
      host.spi_frame({`SPI_CMD_SET_ADDR, a, `SPI_CMD_WRITE, v}, r);
    end else begin
      host.i2c_start();
      ib({`I2C_ADDR_UPPER, straps, 1'b0}, 1'b1, q);
      ib(a, 1'b1, q);
      ib(v, 1'b1, q);
      host.i2c_stop();
    end
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    logic [31:0] r;
    logic [8:0] r9;
    logic [7:0] q;
    if (strap) begin
      host.spi_frame({`SPI_CMD_SET_ADDR, a, `SPI_CMD_READ, 8'h00}, r);
      v = r[7:0];
    end else begin
      host.i2c_start();
      ib({`I2C_ADDR_UPPER, straps, 1'b0}, 1'b1, q);
      ib(a, 1'b1, q);
      host.i2c_start();
      ib({`I2C_ADDR_UPPER, straps, 1'b1}, 1'b1, q);
      host.i2c_byte(9'h1FF, r9);
      host.i2c_stop();
      v = r9[8:1];
    end
  endtask
  initial begin
    repeat (90000) @(posedge ref_clk_i);
    n_errors++;
    $display("unexpected at %0t: run did not finish", $time);
    end_sim();
  end
  initial begin
    tick(4);
    rst_n_i = 1'b1;
    tick(10);
    for (int i = 0; i < 14; i++) begin
      rd(cal_addr[i], d);
      check(d, `CFG_RESET);
    end
    for (int i = 0; i < 14; i++) begin
      rs = nx(rs);
      mem[i] = rs[7:0];
      straps[1:0] = rs[9:8]; // lower straps must not matter in spi
      wr(cal_addr[i], mem[i]);
    end
    for (int i = 0; i < 14; i++) begin
      rd(cal_addr[i], d);
      check(d, mem[i]);
    end
    // read with increment, then plain reads from the advanced pointer
    host.spi_frame({`SPI_CMD_SET_ADDR, `ADDR_HISTORY_DELAY, `SPI_CMD_READ_INC, 8'h00}, r32);
    check(r32[7:0], mem[2]);
    host.spi_frame({`SPI_CMD_READ, 8'h00, `SPI_CMD_READ, 8'h00}, r32);
    check(r32[23:16], mem[3]);
    check(r32[7:0], mem[3]);
    check({7'h0, pend}, 8'h01);
    cal_seen = 0;
    wr(`ADDR_CALIBRATION, 8'h01);
    check({7'h0, pend}, 8'h00);
    check(cal_seen[7:0], 8'h01);
    wr(8'h3F, 8'hA5);
    rd(8'h3F, d);
    check(d, 8'h00);
    rd(`ADDR_CALIBRATION, d);
    check(d, 8'h00);
    $display("test spi registers done");
    for (int k = 0; k < 8; k++) begin
      wr(`ADDR_ALARM_CTRL, {6'h0, k[1], k[0]});
      rs = nx(rs);
      locked = k[2];
      sel = rs[0]; // always a definite level
      tick(8);
      check({5'h0, use2, alarm_oe, alarm}, {5'h0, sel, k[0], ~k[2] ^ k[1]});
      rd(`ADDR_STATUS, d);
      check(d, {7'h0, ~k[2]});
    end
    $display("test alarm and select done");
    strap = 1'b0;
    straps = 3'b101;
    rst_n_i = 1'b0;
    tick(4);
    rst_n_i = 1'b1;
    tick(10);
    for (int j = 0; j < 3; j++) begin
      host.i2c_start();
      ib({`I2C_ADDR_UPPER, straps ^ (3'b001 << j), 1'b0}, 1'b0, d);
      host.i2c_stop();
    end
    wr(`ADDR_HS_DIVIDER, 8'h5A);
    check({7'h0, pend}, 8'h01);
    rd(`ADDR_HS_DIVIDER, d);
    check(d, 8'h5A);
    $display("test i2c done");
    end_sim();
  end
endmodule
